// ===== pkg/qpt_regs.vh
`ifndef QPT_REGS_VH
`define QPT_REGS_VH

// Address-byte register field values.
`define QPT_ADDR_CH0 3'h0
`define QPT_ADDR_CH1 3'h1
`define QPT_ADDR_CH2 3'h2
`define QPT_ADDR_CH3 3'h3
`define QPT_ADDR_SELECT 3'h7

// Select control register layout and power-up value.
`define QPT_SEL_NV_BIT 0
`define QPT_SEL_BANK_LO 1
`define QPT_SEL_BANK_HI 2
`define QPT_SEL_RESET 8'h00

// Slave address byte layout.
`define QPT_SA_TYPE_HI 7
`define QPT_SA_TYPE_LO 4
`define QPT_SA_HWADDR_HI 3
`define QPT_SA_HWADDR_LO 1
`define QPT_SA_DIR_BIT 0

// Device type identifier; this value is arbitrary.
`define QPT_DEV_TYPE_DEFAULT 4'h9

// Nonvolatile write cycle time and its cycle count at the system clock.
`define QPT_NV_WRITE_TIME_US 5000
`define QPT_CLK_FREQ_MHZ 200
`define QPT_NV_WRITE_CYCLES (`QPT_NV_WRITE_TIME_US * `QPT_CLK_FREQ_MHZ)
`define QPT_NV_TIMER_W 20

`endif

// ===== logic/qpt_slave.v
// Behaviour
// - Channel comes from the next address byte.
// - Address 0-3 channels, 7 select control.
// - Byte write: three bytes, each acknowledged.
// - Volatile writes leave device ready after STOP.
// - Stored write with protect high starts cycle.
// - Busy cycle ignores master, data released.
// - Stored write also updates channel wiper.
// - Page bytes acknowledged, channel counter increments.
// - Channel counter wraps from 3 to 0.
// - Extra page bytes overwrite following the counter.
// - Page STOP starts cycle, inputs disabled meanwhile.
// - Page bytes also written to wipers.
// - Move/read copies stored value into wiper.
// - Random read header bytes all acknowledged.
// - Send bytes while master acknowledges each.
// - Read starts at pointer, increments, wraps.
// - Power-up pointer is bank 0 channel 0.
// - Select control: bank bits 2:1, nv bit 0.
// - NV bit clear picks wiper, set picks bank.
// - Slave address: type, pin address, direction.
// - No acknowledge to slave address while busy.
`timescale 1ns/1ps
`include "qpt_regs.vh"

module qpt_slave #(
  parameter [3:0] DEV_TYPE        = `QPT_DEV_TYPE_DEFAULT,
  parameter       NV_WRITE_CYCLES = `QPT_NV_WRITE_CYCLES
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  input  wire        hw_address_pin_0,
  input  wire        hw_address_pin_1,
  input  wire        hw_address_pin_2,
  input  wire        write_enable_pin,
  output wire [31:0] wiper_position,
  output wire        nv_busy
);

  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_RXB   = 5'b00010;
  localparam [4:0] ST_RXACK = 5'b00100;
  localparam [4:0] ST_TXB   = 5'b01000;
  localparam [4:0] ST_TXACK = 5'b10000;

  localparam [1:0] K_SA = 2'h0;
  localparam [1:0] K_AD = 2'h1;
  localparam [1:0] K_DT = 2'h2;

  localparam integer NV_LOAD_I = NV_WRITE_CYCLES - 1;
  localparam [`QPT_NV_TIMER_W-1:0] NV_LOAD = NV_LOAD_I[`QPT_NV_TIMER_W-1:0];

  reg        scl_m;
  reg        scl_s;
  reg        scl_d;
  reg        sda_m;
  reg        sda_s;
  reg        sda_d;
  reg  [2:0] pin_m;
  reg  [2:0] pin_s;
  reg        wp_m;
  reg        wp_s;

  reg  [4:0] state_reg;
  reg  [1:0] kind_reg;
  reg  [3:0] cnt_reg;
  reg  [7:0] rx_sh_reg;
  reg  [7:0] tx_sh_reg;
  reg        rd_mode_reg;
  reg        ack_reg;
  reg        sda_oe_reg;
  reg  [2:0] tgt_reg;
  reg  [1:0] ch_reg;
  reg  [7:0] sel_ctl_reg;
  reg        busy_reg;
  reg  [`QPT_NV_TIMER_W-1:0] nv_timer_reg;
  reg  [7:0] wiper_reg [0:3];
  reg  [7:0] nv_mem_reg [0:15];
  reg  [7:0] pend_data_reg [0:3];
  reg  [3:0] pend_valid_reg;
  reg  [1:0] pend_bank_reg;
  reg  [7:0] rd_byte;

  integer i;

  wire [1:0] bank_sel = sel_ctl_reg[`QPT_SEL_BANK_HI:`QPT_SEL_BANK_LO];
  wire       nv_sel   = sel_ctl_reg[`QPT_SEL_NV_BIT];
  wire       is_chan  = ~tgt_reg[2];
  wire       is_sel   = (tgt_reg == `QPT_ADDR_SELECT);

  // Bus pins and straps arrive from outside, so each passes two flops first.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      pin_m <= 3'h0;
      pin_s <= 3'h0;
      wp_m  <= 1'b0;
      wp_s  <= 1'b0;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      pin_m <= {hw_address_pin_2, hw_address_pin_1, hw_address_pin_0};
      pin_s <= pin_m;
      wp_m  <= write_enable_pin;
      wp_s  <= wp_m;
    end
  end

  // Edge and bus-condition detection looks only at the second and third stages.
  wire scl_rise   = scl_s & ~scl_d;
  wire scl_fall   = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // Slave address check against the type identifier and strap pins.
  wire sa_match = (rx_sh_reg[`QPT_SA_TYPE_HI:`QPT_SA_TYPE_LO] == DEV_TYPE) &&
                  (rx_sh_reg[`QPT_SA_HWADDR_HI:`QPT_SA_HWADDR_LO] == pin_s);

  // Byte offered to the master, chosen by the pointer and the select bits.
  always @* begin
    rd_byte = 8'h00;
    if (is_sel) begin
      rd_byte = sel_ctl_reg;
    end else if (is_chan) begin
      if (nv_sel) begin
        rd_byte = nv_mem_reg[{bank_sel, ch_reg}];
      end else begin
        rd_byte = wiper_reg[ch_reg];
      end
    end
  end

  // Loads the transmit shifter and performs the move into the wiper.
  task load_tx;
    begin
      tx_sh_reg  <= rd_byte;
      sda_oe_reg <= ~rd_byte[7];
      cnt_reg    <= 4'h0;
      state_reg  <= ST_TXB;
      if (is_chan && nv_sel) begin
        wiper_reg[ch_reg] <= rd_byte;
      end
    end
  endtask

  // Protocol engine, register file and nonvolatile write timer.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= ST_IDLE;
      kind_reg       <= K_SA;
      cnt_reg        <= 4'h0;
      rx_sh_reg      <= 8'h00;
      tx_sh_reg      <= 8'h00;
      rd_mode_reg    <= 1'b0;
      ack_reg        <= 1'b0;
      sda_oe_reg     <= 1'b0;
      tgt_reg        <= `QPT_ADDR_CH0;
      ch_reg         <= 2'h0;
      sel_ctl_reg    <= `QPT_SEL_RESET;
      busy_reg       <= 1'b0;
      nv_timer_reg   <= {`QPT_NV_TIMER_W{1'b0}};
      pend_valid_reg <= 4'h0;
      pend_bank_reg  <= 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
        wiper_reg[i]     <= 8'h00;
        pend_data_reg[i] <= 8'h00;
      end
      for (i = 0; i < 16; i = i + 1) begin
        nv_mem_reg[i] <= 8'h00;
      end
    end else if (busy_reg) begin
      // The bus is ignored entirely and the data line stays released.
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
      if (nv_timer_reg == {`QPT_NV_TIMER_W{1'b0}}) begin
        busy_reg       <= 1'b0;
        pend_valid_reg <= 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
          if (pend_valid_reg[i]) begin
            nv_mem_reg[{pend_bank_reg, i[1:0]}] <= pend_data_reg[i];
          end
        end
      end else begin
        nv_timer_reg <= nv_timer_reg - 1'b1;
      end
    end else if (start_cond) begin
      // Outside a busy cycle, a START, repeated or not, always restarts address reception.
      state_reg  <= ST_RXB;
      kind_reg   <= K_SA;
      cnt_reg    <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
      if (|pend_valid_reg) begin
        if (wp_s) begin
          busy_reg     <= 1'b1;
          nv_timer_reg <= NV_LOAD;
        end else begin
          pend_valid_reg <= 4'h0;
        end
      end
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ST_RXB: begin
          if (scl_rise) begin
            rx_sh_reg <= {rx_sh_reg[6:0], sda_s};
            cnt_reg   <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            case (kind_reg)
              K_SA: begin
                if (sa_match) begin
                  rd_mode_reg <= rx_sh_reg[`QPT_SA_DIR_BIT];
                  sda_oe_reg  <= 1'b1;
                  state_reg   <= ST_RXACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
              K_AD: begin
                // Upper bits are don't-care; only the register field is decoded.
                tgt_reg <= rx_sh_reg[2:0];
                if (!rx_sh_reg[2]) begin
                  ch_reg <= rx_sh_reg[1:0];
                end
                sda_oe_reg <= 1'b1;
                state_reg  <= ST_RXACK;
              end
              default: begin
                if (is_sel) begin
                  sel_ctl_reg <= {5'h00, rx_sh_reg[2:0]};
                end else if (is_chan) begin
                  wiper_reg[ch_reg] <= rx_sh_reg;
                  if (nv_sel) begin
                    pend_data_reg[ch_reg]  <= rx_sh_reg;
                    pend_valid_reg[ch_reg] <= 1'b1;
                    pend_bank_reg          <= bank_sel;
                  end
                  ch_reg <= ch_reg + 2'h1;
                end
                // Unused addresses fall through here and touch nothing.
                sda_oe_reg <= 1'b1;
                state_reg  <= ST_RXACK;
              end
            endcase
          end
        end
        ST_RXACK: begin
          if (scl_fall) begin
            cnt_reg    <= 4'h0;
            sda_oe_reg <= 1'b0;
            state_reg  <= ST_RXB;
            if (kind_reg == K_SA && rd_mode_reg) begin
              load_tx;
            end else if (kind_reg == K_SA) begin
              kind_reg <= K_AD;
            end else begin
              kind_reg <= K_DT;
            end
          end
        end
        ST_TXB: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_TXACK;
            end else begin
              tx_sh_reg  <= {tx_sh_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_sh_reg[6];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            ack_reg <= ~sda_s;
            if (!sda_s && is_chan) begin
              ch_reg <= ch_reg + 2'h1;
            end
          end else if (scl_fall) begin
            if (ack_reg) begin
              load_tx;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg  <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data: the pad only ever pulls low, so the driven level is fixed.
  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_reg;
  assign nv_busy = busy_reg;

  // Wiper positions leave the block as one flat bus, channel 0 lowest.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_wiper
      assign wiper_position[8*g+7:8*g] = wiper_reg[g];
    end
  endgenerate

endmodule // qpt_slave

// ===== tb/qpt_master.sv
`timescale 1ns/1ps
// Bus master model; a released SDA reads high through the bus pull-up.
module qpt_master (
  output logic scl   = 1'b1,
  output logic sda_m = 1'b1,
  input  wire  sda
);
  localparam int Q = 12;
  logic r;
  // START or repeated START: SDA falls while SCL is high.
  // SDA rises a quarter bit late so a slave still holding ACK cannot fake a STOP.
  task automatic start();
    #Q sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
  endtask
  // STOP, then bus idle long enough for the slave to see it.
  task automatic stop();
    #Q sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #(4*Q);
  endtask
  // One 48 ns bit; data only moves while SCL is low.
  task automatic bit_io(input logic b, output logic v);
    #Q sda_m = b;
    #Q scl = 1'b1;
    #Q v = sda;
    #Q scl = 1'b0;
  endtask
  // Bytes go MSB first; the ninth bit carries the acknowledge.
  task automatic wbyte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    a = !r;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!mack, r);
  endtask
endmodule // qpt_master

// ===== tb/qpt_slave_assertions.sv
`timescale 1ns/1ps
// Port checks; counters hold the busy length and the age of the last STOP.
module qpt_chk #(
  parameter [3:0] DEV_TYPE        = 4'h0,
  parameter       NV_WRITE_CYCLES = 300
) (
  input wire        clk_sys,
  input wire        rstn,
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        hw_address_pin_0,
  input wire        hw_address_pin_1,
  input wire        hw_address_pin_2,
  input wire        write_enable_pin,
  input wire [31:0] wiper_position,
  input wire        nv_busy
);
  reg [31:0] bcnt_reg;
  reg [3:0]  age_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // The age saturates so a long idle never looks like a fresh STOP.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bcnt_reg <= 32'h0;
      age_reg  <= 4'hf;
    end else begin
      bcnt_reg <= nv_busy ? bcnt_reg + 32'h1 : 32'h0;
      age_reg  <= ($past(scl_in) && scl_in && !$past(sda_in) && sda_in) ? 4'h0 :
                  (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
    end
  end
  a_busy_quiet: assert property (nv_busy |-> !sda_oe)
    else $error("slave drives SDA while busy");
  a_busy_exact: assert property ($fell(nv_busy) |-> bcnt_reg >= NV_WRITE_CYCLES - 1
    && bcnt_reg <= NV_WRITE_CYCLES + 1) else $error("busy length wrong");
  a_busy_max: assert property (bcnt_reg <= NV_WRITE_CYCLES + 1)
    else $error("busy too long");
  a_reset_clear: assert property ($rose(rstn) |-> wiper_position == 32'h0 && !nv_busy)
    else $error("state not cleared by reset");
  a_hold_busy: assert property (nv_busy && $past(nv_busy) |-> $stable(wiper_position))
    else $error("wiper moved while busy");
  a_busy_wp: assert property ($rose(nv_busy) |-> write_enable_pin)
    else $error("busy with write disabled");
  a_busy_stop: assert property ($rose(nv_busy) |-> age_reg <= 4'h8)
    else $error("busy without STOP");
  a_stop_free: assert property (age_reg == 4'h6 |-> !sda_oe)
    else $error("SDA driven after STOP");
  c_busy: cover property ($rose(nv_busy));
  c_ack: cover property ($rose(sda_oe));
  c_move: cover property (!nv_busy && $changed(wiper_position));
endmodule // qpt_chk
bind qpt_slave qpt_chk #(.DEV_TYPE(DEV_TYPE), .NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .hw_address_pin_0(hw_address_pin_0), .hw_address_pin_1(hw_address_pin_1),
  .hw_address_pin_2(hw_address_pin_2), .write_enable_pin(write_enable_pin),
  .wiper_position(wiper_position), .nv_busy(nv_busy));

// ===== tb/tb_qpt_slave.sv
`timescale 1ns/1ps
`include "qpt_regs.vh"
// Reference model: packed wipers, stored banks, select control and pointer.
module tb_qpt_slave;
  localparam int NVC = 300;
  logic            clk_sys = 1'b0;
  logic            rstn = 1'b0;
  logic            wp = 1'b1;
  logic            ack;
  logic [2:0]      hw = 3'h0;
  logic [7:0]      d;
  logic [3:0][7:0] wip = '0;
  logic [3:0][7:0] pend = '0;
  logic [3:0][7:0] sto [4] = '{default: '0};
  logic [3:0]      pv = 4'h0;
  wire             scl, sda_m, sda_oe, sda_out, nv_busy;
  wire      [31:0] wiper_position;
  wire             sda = sda_m & (~sda_oe | sda_out);
  int num_errors = 0, n_compared = 0, seed = 17, cyc = 0, sel = 0, ptr = 0, pb = 0;
  always #2.5 clk_sys = ~clk_sys;
  qpt_master master_u (.scl(scl), .sda_m(sda_m), .sda(sda));
  qpt_slave #(.NV_WRITE_CYCLES(NVC)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .hw_address_pin_0(hw[0]), .hw_address_pin_1(hw[1]),
    .hw_address_pin_2(hw[2]), .write_enable_pin(wp), .wiper_position(wiper_position),
    .nv_busy(nv_busy));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run for good.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic sa(input logic rw);
    // A half-nanosecond offset keeps every bus edge clear of a rising clock edge.
    @(posedge clk_sys) #0.5;
    master_u.start();
    master_u.wbyte({`QPT_DEV_TYPE_DEFAULT, hw, rw}, ack);
  endtask
  // Stored bytes stay pending until STOP, then commit only if writes are enabled.
  task automatic wr(input logic [2:0] a, input int n, input logic [7:0] sv);
    logic [7:0] b;
    sa(1'b0);
    chk(ack, 1'b1);
    master_u.wbyte({5'h00, a}, ack);
    chk(ack, 1'b1);
    if (a < 4) ptr = a;
    for (int i = 0; i < n; i++) begin
      b = (a == 3'h7) ? sv : 8'($random(seed));
      master_u.wbyte(b, ack);
      chk(ack, 1'b1);
      if (a == 3'h7) sel = b[2:0];
      if (a < 4) begin
        wip[ptr] = b;
        if (sel[0]) begin
          pend[ptr] = b;
          pv[ptr] = 1'b1;
          pb = sel >> 1;
        end
        ptr = (ptr + 1) % 4;
      end
    end
    master_u.stop();
    repeat (10) @(posedge clk_sys);
    chk(wiper_position, wip);
    chk(nv_busy, wp && pv != 4'h0);
    if (nv_busy) begin
      sa(1'b0);
      master_u.stop();
      chk(ack, 1'b0);
      for (int k = 0; k < NVC + 50 && nv_busy; k++) @(posedge clk_sys);
      chk(nv_busy, 1'b0);
      for (int k = 0; k < 4; k++) if (pv[k]) sto[pb][k] = pend[k];
    end
    pv = 4'h0;
  endtask
  // Each stored byte read is also moved into its wiper.
  task automatic rd(input logic [2:0] a, input int n);
    sa(1'b0);
    master_u.wbyte({5'h00, a}, ack);
    if (a < 4) ptr = a;
    sa(1'b1);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      master_u.rbyte(i < n - 1, d);
      if (a > 3) begin
        chk(d, (a == 3'h7) ? sel : 0);
      end else begin
        if (sel[0]) wip[ptr] = sto[sel >> 1][ptr];
        chk(d, wip[ptr]);
        if (i < n - 1) ptr = (ptr + 1) % 4;
      end
    end
    master_u.stop();
    repeat (10) @(posedge clk_sys);
    chk(wiper_position, wip);
  endtask
  initial begin
    hw = 3'($random(seed));
    repeat (12) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(wiper_position, 32'h0);
    wr(3'h0, 4, 8'h00);
    wr(3'h5, 1, 8'h00);
    $display("volatile writes done");
    wr(3'h7, 1, 8'h03);
    wr(3'h2, 1, 8'h00);
    $display("stored byte write done");
    wr(3'h7, 1, 8'h05);
    wr(3'h1, 6, 8'h00);
    $display("page write done");
    @(posedge clk_sys) #1 wp = 1'b0;
    wr(3'h3, 1, 8'h00);
    @(posedge clk_sys) #1 wp = 1'b1;
    $display("disabled write done");
    wr(3'h7, 1, 8'h06);
    wr(3'h0, 4, 8'h00);
    rd(3'h0, 2);
    wr(3'h7, 1, 8'h05);
    rd(3'h1, 6);
    rd(3'h7, 2);
    rd(3'h5, 1);
    $display("move read done");
    end_sim();
  end
endmodule // tb_qpt_slave
